// ---- acr_fifo.sv ----
// acr_fifo: small synchronous fifo with flush, valid/ready both sides
// assumes one clock, asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module acr_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
    ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign in_ready  = (count_reg != (AW+1)'(DEPTH)) && !flush;
  assign out_valid = (count_reg != '0) && !flush;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_reg[rd_ptr_reg];

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (flush) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) wr_ptr_reg <= ptr_inc(wr_ptr_reg);
      if (pop) rd_ptr_reg <= ptr_inc(rd_ptr_reg);
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// ---- acr_top.sv ----
// acr_top: conversion / sleep / serial readout cycle of a 16-bit converter
// assumes pins arrive asynchronous to ref_clk; front end supplies results
// How it works
// R1: chip select low enables data output driver and wakes the device
// R2: after each conversion enter sleep, remain while chip select high
// R3: chip select rising during shifting aborts and starts new conversion
// R4: data output high impedance whenever chip select is high
// R5: in conversion and sleep, low chip select shows conversion status
// R6: internal clock mode drives serial clock and enables weak pullup
// R7: external clock mode treats serial clock purely as an input
// R8: clock mode taken from serial clock level at reset or select fall
// R9: frequency pin low uses internal oscillator, clocked pin is system clock
// R10: states cycle conversion, sleep, data output in fixed order
// R11: finished result held unchanged in shift register during sleep
// R12: select high before first serial clock rise returns to sleep
// R13: select low past first serial clock rise starts shifting result
// R14: each frame carries the conversion just completed, no stale data
// R15: data changes on falling serial clock, host samples on rising
// R16: output ends after 19 bits or select rise, then new conversion
// R17: serial clocks beyond the frame give logic high bits
// R18: modes come from select and clock timing only, no registers
// R19: calibration lives inside each conversion, invisible to host
// R20: held in reset while supply below threshold
// R21: power-on reset of about one millisecond clears all state; code leaves the system clock oscillator counters running
// R22: frame is status flag, filler low, sign, 16 result bits msb first
// R23: status flag high during conversion, low when it completes
// R24: overrange sign and msb high, underrange both low
// R25: falling edge after last result bit drives output high
// R26: host checks status low before clocking out a result
`timescale 1ns/1ps
`default_nettype none

package acr_pkg;
  localparam int CLK_PERIOD_PS   = 5000;
  localparam int POR_TIME_US     = 1000;
  localparam int POR_CYCLES      = POR_TIME_US * 1000000 / CLK_PERIOD_PS;
  localparam int INT_OSC_HZ      = 139800;
  localparam int INT_OSC_DIV     = 1000000000 / (INT_OSC_HZ / 1000)
                                   / CLK_PERIOD_PS;
  localparam int ISCK_HALF_TICKS = 4;
  localparam int FRAME_BITS      = 19;
  localparam int RESULT_BITS     = 16;
  localparam int EXT_OSC_IDLE    = 4096;
  localparam logic MODE_INT      = 1'b0;
  localparam logic MODE_EXT      = 1'b1;
  typedef enum logic [1:0] {ACR_CONV, ACR_SLEEP, ACR_OUT} acr_state_e;
endpackage

module acr_top #(
  parameter int POR_CYCLES   = acr_pkg::POR_CYCLES,
  parameter int FIFO_DEPTH   = 8,
  parameter int EXT_OSC_IDLE = acr_pkg::EXT_OSC_IDLE
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        supply_ok,
  input  wire logic        cs_n,
  input  wire logic        sck_in,
  output logic             sck_out,
  output logic             sck_oe,
  output logic             sck_pullup_en,
  output logic             sdo_out,
  output logic             sdo_oe,
  input  wire logic        frequency_control_pin,
  output logic             sys_tick,
  output logic             conv_start,
  input  wire logic        res_valid,
  output logic             res_ready,
  input  wire logic        res_sign,
  input  wire logic [15:0] res_data,
  output logic             ext_mode,
  output logic             por_busy
);
  localparam int CW = acr_pkg::RESULT_BITS + 1;
  localparam int SW = acr_pkg::FRAME_BITS - 1;

  logic [1:0]  cs_sync_reg;
  logic [1:0]  sck_sync_reg;
  logic [1:0]  fpin_sync_reg;
  logic [1:0]  sup_sync_reg;
  logic        cs_d_reg;
  logic        sck_d_reg;
  logic        fpin_d_reg;
  logic [31:0] por_cnt_reg;
  logic        por_reg;
  logic        por_done;
  logic [15:0] osc_cnt_reg;
  logic [15:0] fidle_cnt_reg;
  logic        ext_osc_reg;
  logic [2:0]  isck_cnt_reg;
  logic        isck_reg;
  logic        mode_reg;
  acr_pkg::acr_state_e state_reg;
  logic        started_reg;
  logic [4:0]  bit_cnt_reg;
  logic [SW-1:0] shift_reg;
  logic        sdo_reg;
  logic        start_reg;
  logic        cs_s;
  logic        sck_s;
  logic        cs_fall;
  logic        cs_rise;
  logic        osc_tick;
  logic        sck_rise;
  logic        sck_fall;
  logic        isck_rise;
  logic        isck_fall;
  logic        f_valid;
  logic        f_ready;
  logic [CW-1:0] f_data;

  function automatic logic edge_of(input logic now, input logic was,
                                   input logic rising);
    edge_of = rising ? (now && !was) : (!now && was);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_sync_reg   <= 2'h3;
      sck_sync_reg  <= 2'h0;
      fpin_sync_reg <= 2'h0;
      sup_sync_reg  <= 2'h0;
      cs_d_reg      <= 1'b1;
      sck_d_reg     <= 1'b0;
      fpin_d_reg    <= 1'b0;
    end else begin
      cs_sync_reg   <= {cs_sync_reg[0], cs_n};
      sck_sync_reg  <= {sck_sync_reg[0], sck_in};
      fpin_sync_reg <= {fpin_sync_reg[0], frequency_control_pin};
      sup_sync_reg  <= {sup_sync_reg[0], supply_ok};
      cs_d_reg      <= cs_sync_reg[1];
      sck_d_reg     <= sck_sync_reg[1];
      fpin_d_reg    <= fpin_sync_reg[1];
    end
  end

  assign cs_s    = cs_sync_reg[1];
  assign sck_s   = sck_sync_reg[1];
  assign cs_fall = edge_of(cs_s, cs_d_reg, 1'b0);
  assign cs_rise = edge_of(cs_s, cs_d_reg, 1'b1);

  ////////////////////////////////////////////////////////////////////////
  // power-on reset hold and timer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      por_cnt_reg <= '0;
      por_reg     <= 1'b1;
    end else if (!sup_sync_reg[1]) begin
      por_cnt_reg <= '0; // R20
      por_reg     <= 1'b1;
    end else if (por_reg) begin
      if (por_done) begin
        por_reg <= 1'b0; // R21
      end else begin
        por_cnt_reg <= por_cnt_reg + 32'h1;
      end
    end
  end

  assign por_busy = por_reg;
  assign por_done = sup_sync_reg[1]
                    && por_cnt_reg == 32'(POR_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////
  // system clock source: internal divider or frequency pin edges
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_cnt_reg   <= '0;
      fidle_cnt_reg <= '0;
      ext_osc_reg   <= 1'b0;
    end else begin
      osc_cnt_reg <= (osc_cnt_reg == 16'(acr_pkg::INT_OSC_DIV - 1))
                     ? 16'h0 : osc_cnt_reg + 16'h1;
      if (fpin_sync_reg[1] != fpin_d_reg) begin
        fidle_cnt_reg <= '0;
        ext_osc_reg   <= 1'b1; // R9
      end else if (fidle_cnt_reg == 16'(EXT_OSC_IDLE - 1)) begin
        ext_osc_reg   <= 1'b0; // R9
      end else begin
        fidle_cnt_reg <= fidle_cnt_reg + 16'h1;
      end
    end
  end

  assign osc_tick = ext_osc_reg
                    ? edge_of(fpin_sync_reg[1], fpin_d_reg, 1'b1)
                    : (osc_cnt_reg == 16'h0);
  assign sys_tick = osc_tick && !por_reg;

  ////////////////////////////////////////////////////////////////////////
  // serial clock mode latch
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= acr_pkg::MODE_INT;
    end else if (por_reg) begin
      mode_reg <= sck_s; // R8 R20
    end else if (cs_fall) begin
      mode_reg <= sck_s; // R8 R18
    end
  end

  assign ext_mode      = mode_reg;
  assign sck_pullup_en = (mode_reg == acr_pkg::MODE_INT); // R6

  ////////////////////////////////////////////////////////////////////////
  // internal serial clock generator, system tick divided by eight
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      isck_cnt_reg <= '0;
      isck_reg     <= 1'b0;
    end else if (state_reg != acr_pkg::ACR_OUT || cs_s
                 || mode_reg == acr_pkg::MODE_EXT) begin
      isck_cnt_reg <= '0;
      isck_reg     <= 1'b0;
    end else if (sys_tick) begin
      if (isck_cnt_reg == 3'(acr_pkg::ISCK_HALF_TICKS - 1)) begin
        isck_cnt_reg <= '0;
        isck_reg     <= !isck_reg;
      end else begin
        isck_cnt_reg <= isck_cnt_reg + 3'h1;
      end
    end
  end

  assign isck_rise = sys_tick && !isck_reg
                     && isck_cnt_reg == 3'(acr_pkg::ISCK_HALF_TICKS - 1);
  assign isck_fall = sys_tick && isck_reg
                     && isck_cnt_reg == 3'(acr_pkg::ISCK_HALF_TICKS - 1);
  // R7: external mode only reads the pin
  assign sck_rise  = (mode_reg == acr_pkg::MODE_EXT)
                     ? edge_of(sck_s, sck_d_reg, 1'b1) : isck_rise;
  assign sck_fall  = (mode_reg == acr_pkg::MODE_EXT)
                     ? edge_of(sck_s, sck_d_reg, 1'b0) : isck_fall;
  assign sck_out   = isck_reg;
  assign sck_oe    = (mode_reg == acr_pkg::MODE_INT) && !cs_s
                     && state_reg == acr_pkg::ACR_OUT; // R6 R7

  ////////////////////////////////////////////////////////////////////////
  // result buffer from the modulator
  acr_fifo #(
    .WIDTH (CW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (ref_clk),
    .rst_n     (rst_n),
    .flush     (start_reg || por_reg),
    .in_valid  (res_valid),
    .in_ready  (res_ready),
    .in_data   ({res_sign, res_data}),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  // R19: calibration is inside the modulator conversion
  assign f_ready    = (state_reg == acr_pkg::ACR_CONV) && !start_reg;
  assign conv_start = start_reg;

  ////////////////////////////////////////////////////////////////////////
  // conversion cycle state machine
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg   <= acr_pkg::ACR_CONV;
      started_reg <= 1'b0;
      bit_cnt_reg <= '0;
      start_reg   <= 1'b0;
    end else if (por_reg) begin
      state_reg   <= acr_pkg::ACR_CONV; // R21
      started_reg <= 1'b0;
      bit_cnt_reg <= '0;
      start_reg   <= por_done; // R21
    end else begin
      start_reg <= 1'b0;
      unique case (state_reg)
        acr_pkg::ACR_CONV: begin
          if (f_valid && f_ready) begin
            state_reg <= acr_pkg::ACR_SLEEP; // R2 R10
          end
        end
        acr_pkg::ACR_SLEEP: begin
          if (!cs_s) begin
            state_reg   <= acr_pkg::ACR_OUT; // R1 R10
            started_reg <= 1'b0;
            bit_cnt_reg <= '0;
          end
        end
        acr_pkg::ACR_OUT: begin
          if (cs_rise && !started_reg) begin
            state_reg <= acr_pkg::ACR_SLEEP; // R12
          end else if (cs_rise) begin
            state_reg <= acr_pkg::ACR_CONV; // R3 R16
            start_reg <= 1'b1;
          end else if (sck_rise && !started_reg) begin
            started_reg <= 1'b1; // R13
          end else if (sck_fall && started_reg) begin
            if (bit_cnt_reg == 5'(acr_pkg::FRAME_BITS - 1)) begin
              state_reg <= acr_pkg::ACR_CONV; // R16 R10
              start_reg <= 1'b1;
            end else begin
              bit_cnt_reg <= bit_cnt_reg + 5'h1;
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output shift register
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= '0;
    end else if (por_reg) begin
      shift_reg <= '0;
    end else if (state_reg == acr_pkg::ACR_CONV && f_valid && f_ready) begin
      shift_reg <= {1'b0, f_data}; // R22 R24 R14
    end else if (state_reg == acr_pkg::ACR_OUT && started_reg
                 && sck_fall) begin
      shift_reg <= {shift_reg[SW-2:0], 1'b1}; // R15 R17
    end
  end

  // R11: shift register only moves on power-on reset clear, load or serial clock falling edges
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sdo_reg <= 1'b1;
    end else begin
      unique case (state_reg)
        acr_pkg::ACR_CONV: sdo_reg <= !(f_valid && f_ready); // R5 R23
        acr_pkg::ACR_SLEEP: sdo_reg <= 1'b0; // R5 R23
        acr_pkg::ACR_OUT: begin
          if (sck_fall && started_reg) begin
            if (bit_cnt_reg == 5'(acr_pkg::FRAME_BITS - 1)) begin
              sdo_reg <= 1'b1; // R25
            end else begin
              sdo_reg <= shift_reg[SW-1]; // R15 R22
            end
          end
        end
      endcase
    end
  end

  assign sdo_out = sdo_reg;
  assign sdo_oe  = !cs_s && !por_reg; // R1 R4
endmodule
`default_nettype wire

// ---- acr_top_props.sv ----
// acr_top_props: pin-level checks on acr_top
// assumes binding onto acr_top, single ref_clk domain
`timescale 1ns/1ps
`default_nettype none
module acr_top_props (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sck_in,
  input wire logic sck_oe,
  input wire logic sck_pullup_en,
  input wire logic sdo_out,
  input wire logic sdo_oe,
  input wire logic conv_start,
  input wire logic ext_mode,
  input wire logic por_busy
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  property p_sdo_hiz; cs_n [*3] |-> !sdo_oe; endproperty
  a_sdo_hiz: assert property (p_sdo_hiz)
    else $error("sdo driven while deselected");
  property p_wake; $fell(cs_n) && !por_busy |-> ##[1:4] sdo_oe; endproperty
  a_wake: assert property (p_wake)
    else $error("sdo not enabled after select");
  property p_int_drive; sck_oe |-> !ext_mode && sck_pullup_en; endproperty
  a_int_drive: assert property (p_int_drive)
    else $error("sck driven outside internal mode");
  property p_ext_input; ext_mode |-> !sck_oe && !sck_pullup_en; endproperty
  a_ext_input: assert property (p_ext_input)
    else $error("sck not an input in external mode");
  property p_por_quiet; por_busy |-> !sdo_oe && !sck_oe; endproperty
  a_por_quiet: assert property (p_por_quiet)
    else $error("pins driven during power-on reset");
  property p_por_start; $fell(por_busy) |-> ##[0:2] conv_start; endproperty
  a_por_start: assert property (p_por_start)
    else $error("no conversion after power-on reset");
  property p_shift_edge;
    (ext_mode && sck_in && !cs_n) [*6] |-> $stable(sdo_out);
  endproperty
  a_shift_edge: assert property (p_shift_edge)
    else $error("sdo changed while sck high");
  property p_last_high; conv_start && !cs_n |=> sdo_out [*3]; endproperty
  a_last_high: assert property (p_last_high)
    else $error("sdo not high at new conversion");
  c_por: cover property ($fell(por_busy));
  c_frame_end: cover property (conv_start && !cs_n);
  c_int_sck: cover property (sck_oe);
endmodule

bind acr_top acr_top_props u_props (
  .ref_clk(ref_clk), .rst_n(rst_n), .cs_n(cs_n), .sck_in(sck_in),
  .sck_oe(sck_oe), .sck_pullup_en(sck_pullup_en), .sdo_out(sdo_out),
  .sdo_oe(sdo_oe), .conv_start(conv_start), .ext_mode(ext_mode),
  .por_busy(por_busy)
);
`default_nettype wire

// ---- acr_host.sv ----
// acr_host: host side of the 3-wire link, 64 ns serial clock
// assumes bench resolves sck and sdo wires
`timescale 1ns/1ps
`default_nettype none
module acr_host (
  output logic        cs_n,
  output logic        sck,
  output logic        sck_en,
  input  wire logic   sdo,
  output logic [31:0] frame
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b1;
    sck_en = 1'b1;
    frame = 32'h0;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic xfer(input int n);
    frame = 32'h0;
    sck_en = 1'b1;
    sck = 1'b1;
    #100 cs_n = 1'b0;
    #100;
    for (int i = 0; i < n; i++) begin
      sck = 1'b0;
      #32 sck = 1'b1;
      frame = {frame[30:0], sdo};
      #32;
    end
    sck = 1'b0;
    #32 sck = 1'b1;
    #40 cs_n = 1'b1;
    #200;
  endtask
  task automatic poll(output logic b);
    #100 cs_n = 1'b0;
    #100 b = sdo;
    cs_n = 1'b1;
    #100;
  endtask
  task automatic dip;
    sck_en = 1'b0;
    #100 cs_n = 1'b0;
    #200 cs_n = 1'b1;
    #100 sck_en = 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- acr_top_tb.sv ----
// acr_top_tb: self-checking bench for acr_top with host model
// assumes acr_host partner and bound acr_top_props
`timescale 1ns/1ps
`default_nettype none
module acr_top_tb;
  logic        ref_clk, rst_n, res_valid, res_sign, supply_ok, f0_pin;
  logic        sdo_last = 1'b0;
  logic [15:0] res_data;
  logic        sck_out, sck_oe, sck_pullup_en, sdo_out, sdo_oe;
  logic        conv_start, res_ready, ext_mode, por_busy, sys_tick;
  logic [31:0] frame;
  wire         cs_n, host_sck, host_en, sdo_wire, sck_wire;
  int          n_errors, compares, n_conv, n_tick;
  logic        tab_s [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  logic [15:0] tab_d [4] = '{16'hA5C3, 16'h5234, 16'h8001, 16'h7FFF};
  int          tab_n [4] = '{24, 5, 19, 19};
  assign sck_wire = sck_oe ? sck_out : (host_en ? host_sck : sck_pullup_en);
  assign sdo_wire = sdo_oe ? sdo_out : ~sdo_last;
  acr_top #(.POR_CYCLES(20), .FIFO_DEPTH(8), .EXT_OSC_IDLE(64)) uut (
    .ref_clk(ref_clk), .rst_n(rst_n), .supply_ok(supply_ok), .cs_n(cs_n),
    .sck_in(sck_wire), .sck_out(sck_out), .sck_oe(sck_oe),
    .sck_pullup_en(sck_pullup_en), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
    .frequency_control_pin(f0_pin), .sys_tick(sys_tick),
    .conv_start(conv_start),
    .res_valid(res_valid), .res_ready(res_ready), .res_sign(res_sign),
    .res_data(res_data), .ext_mode(ext_mode), .por_busy(por_busy));
  acr_host host (.cs_n(cs_n), .sck(host_sck), .sck_en(host_en),
                 .sdo(sdo_wire), .frame(frame));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (conv_start === 1'b1) n_conv++;
    if (sys_tick === 1'b1) n_tick++;
    if (sdo_oe === 1'b1) sdo_last <= sdo_out;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, want, input string what);
    compares++;
    if (got !== want) begin
      n_errors++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, want);
    end
  endtask
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic give(input logic s, input logic [15:0] d);
    @(posedge ref_clk) #1;
    res_valid = 1'b1;
    res_sign = s;
    res_data = d;
    for (int i = 0; i < 4000; i++) begin
      @(negedge ref_clk);
      if (res_ready === 1'b1) break;
    end
    chk(res_ready, 32'h1, "result taken");
    @(posedge ref_clk) #1 res_valid = 1'b0;
  endtask
  task automatic fill(output int cnt);
    cnt = 0;
    @(posedge ref_clk) #1;
    res_valid = 1'b1;
    res_data = 16'hDEAD;
    repeat (12) begin
      @(negedge ref_clk);
      if (res_ready === 1'b1) cnt++;
      @(posedge ref_clk);
    end
    #1 res_valid = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    n_errors++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_of_test;
  end
  initial begin
    int          cnt, c0;
    logic        b;
    logic [31:0] f, want;
    rst_n = 1'b0;
    res_valid = 1'b0;
    res_sign = 1'b0;
    res_data = 16'h0000;
    supply_ok = 1'b1;
    f0_pin = 1'b0;
    repeat (5) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    for (int i = 0; i < 200 && por_busy !== 1'b0; i++) @(posedge ref_clk);
    repeat (4) @(posedge ref_clk);
    chk(por_busy, 32'h0, "por done");
    chk(n_conv, 32'h1, "start after reset");
    host.poll(b);
    chk(b, 32'h1, "status while busy");
    for (int k = 0; k < 4; k++) begin
      c0 = n_conv;
      give(tab_s[k], tab_d[k]);
      if (k == 0) begin
        host.poll(b);
        chk(b, 32'h0, "status when done");
        fork
          host.dip();
          begin
            #250;
            chk({sck_oe, sck_pullup_en, ext_mode}, 32'h6, "int sck");
          end
        join
        fill(cnt);
        chk(cnt, 32'h8, "fifo fill");
      end
      host.xfer(tab_n[k]);
      f = {13'h0, 2'b00, tab_s[k], tab_d[k]};
      if (tab_n[k] >= 19)
        want = (f << (tab_n[k] - 19)) | ((32'h1 << (tab_n[k] - 19)) - 1);
      else
        want = f >> (19 - tab_n[k]);
      chk(frame, want, "frame");
      chk(n_conv - c0, 32'h1, "one new conversion");
      chk({sdo_oe, ext_mode}, 32'h1, "idle pins");
      $display("test %0d done", k);
    end
    @(posedge ref_clk) #1 c0 = n_tick;
    repeat (2 * acr_pkg::INT_OSC_DIV) @(posedge ref_clk);
    #1 chk(n_tick - c0, 32'h2, "internal osc ticks");
    for (int i = 0; i < 48; i++) begin
      if (i == 8) c0 = n_tick;
      if (i == 40) chk(n_tick - c0, 32'h10, "external osc ticks");
      f0_pin = ~f0_pin;
      repeat (4) @(posedge ref_clk);
      #1;
    end
    $display("test osc done");
    supply_ok = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1 chk(por_busy, 32'h1, "supply low");
    c0 = n_conv;
    supply_ok = 1'b1;
    repeat (40) @(posedge ref_clk);
    #1 chk({por_busy, sdo_oe}, 32'h0, "supply back");
    chk(n_conv - c0, 32'h1, "start after supply");
    $display("test supply done");
    end_of_test;
  end
endmodule
`default_nettype wire
